// ==== core/rpp_pkg.sv ====
// Shared constants and state types for the removed-pin port read-back block.
package rpp_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] RPP_OFF_P5_PIN_STATE = 8'h00;
  localparam logic [7:0] RPP_OFF_P5_OUTPUT_LATCH = 8'h04;
  localparam logic [7:0] RPP_OFF_P5_DIRECTION = 8'h08;
  localparam logic [7:0] RPP_OFF_P5_FUNCTION_SELECT = 8'h0C;
  localparam logic [7:0] RPP_OFF_P6_PIN_STATE = 8'h10;
  localparam logic [7:0] RPP_OFF_P6_OUTPUT_LATCH = 8'h14;
  localparam logic [7:0] RPP_OFF_P6_DIRECTION = 8'h18;
  localparam logic [7:0] RPP_OFF_P6_FUNCTION_SELECT = 8'h1C;

  // Bits that still have pin logic behind them.
  localparam logic [7:0] RPP_P5_PRESENT = 8'h0D;
  localparam logic [7:0] RPP_P6_PRESENT = 8'hF3;

  // Read values of removed bits in pin-state, output-latch and direction.
  localparam logic [7:0] RPP_P5_ABSENT_ONES = 8'hF2;
  localparam logic [7:0] RPP_P6_ABSENT_ONES = 8'h0C;

  // Read values of removed bits in function-select, strap bit excluded.
  localparam logic [7:0] RPP_PORT5_FUNCTION_SELECT_FIXED = 8'h80;
  localparam logic [7:0] RPP_PORT6_FUNCTION_SELECT_FIXED = 8'h00;

  // Function-select bit of port 5 that follows the external-access strap.
  localparam int RPP_PORT5_FUNCTION_SELECT_STRAP_BIT = 5;

  // Reset values of the stored bits of present pins.
  localparam logic [7:0] RPP_LATCH_RST = 8'hFF;
  localparam logic [7:0] RPP_DIR_RST = 8'hFF;
  localparam logic [7:0] RPP_MODE_RST = 8'h00;
  localparam logic RPP_STRAP_RST = 1'b0;

  // Read data and upper-bit padding of the 32-bit bus.
  localparam logic [31:0] RPP_RDATA_RST = 32'h0000_0000;
  localparam logic [23:0] RPP_RDATA_PAD = 24'h00_0000;

  // Software-visible state of the top level.
  typedef struct packed {
    logic [7:0] p5_latch;
    logic [7:0] p5_dir;
    logic [7:0] port5_function_select;
    logic [7:0] p6_latch;
    logic [7:0] p6_dir;
    logic [7:0] port6_function_select;
    logic strap;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } rpp_regs_t;

  // Pin-facing state of one port bank.
  typedef struct packed {
    logic [7:0] pin_state;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] func;
  } rpp_bank_t;

endpackage

// ==== core/rpp_port_bank.sv ====
// Pin-facing flops of one eight-bit port with hardwired removed bits.
`timescale 1ns/10ps
`default_nettype none

module rpp_port_bank #(
  parameter logic [7:0] PRESENT = 8'hFF,
  parameter logic [7:0] ABSENT_ONES = 8'h00
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stored software values
  input wire logic [7:0] latch,
  input wire logic [7:0] dir,
  input wire logic [7:0] mode,
  // Pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] func,
  // Read-back of the pin levels
  output logic [7:0] pin_state
);
  import rpp_pkg::*;

  rpp_bank_t st_q;
  rpp_bank_t st_d;

  always_comb begin
    st_d = st_q;
    // Removed pins read as one and are never sampled. [R1] [R6]
    st_d.pin_state = (pin_in & PRESENT) | (ABSENT_ONES & ~PRESENT);
    // Present pins behave normally; removed pins are never driven. [R8]
    st_d.pin_out = latch & PRESENT;
    // A direction bit of one means input, so the driver is off.
    st_d.pin_oe = ~dir & PRESENT;
    st_d.func = mode & PRESENT;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_state = st_q.pin_state;
  assign pin_out = st_q.pin_out;
  assign pin_oe = st_q.pin_oe;
  assign func = st_q.func;

endmodule

`default_nettype wire

// ==== core/rpp_top.sv ====
// APB register file of ports 5 and 6 with hardwired removed-pin bits.
//
// What this block does
// R1: Port 5 bits 1,4-7 of pin/latch/direction read 1.
// R2: Port 5 function-select bits 1,4,6 read 0.
// R3: Port 5 function-select bit 5 inverts the strap.
// R4: Port 5 function-select bit 7 reads 1.
// R5: Writes to hardwired bits change nothing at all.
// R6: Port 6 bits 2,3 of pin/latch/direction read 1.
// R7: Port 6 function-select bits 2,3 read 0.
// R8: Bits of present pins keep normal behaviour.
`timescale 1ns/10ps
`default_nettype none

module rpp_top #(
  parameter int ADDR_W = 8,
  parameter logic [7:0] LATCH_RST = rpp_pkg::RPP_LATCH_RST,
  parameter logic [7:0] DIR_RST = rpp_pkg::RPP_DIR_RST,
  parameter logic [7:0] MODE_RST = rpp_pkg::RPP_MODE_RST
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External-access strap level
  input wire logic external_access_strap,
  // Port 5 pins
  input wire logic [7:0] port5_pin_in,
  output logic [7:0] port5_pin_out,
  output logic [7:0] port5_pin_oe,
  output logic [7:0] port5_func_sel,
  // Port 6 pins
  input wire logic [7:0] port6_pin_in,
  output logic [7:0] port6_pin_out,
  output logic [7:0] port6_pin_oe,
  output logic [7:0] port6_func_sel
);
  import rpp_pkg::*;

  rpp_regs_t st_q;
  rpp_regs_t st_d;

  logic [7:0] port5_pin_state;
  logic [7:0] port6_pin_state;

  // Address decode signals.
  logic [7:0] word_addr;
  logic addr_ok;
  logic hit_p5_pin;
  logic hit_p5_latch;
  logic hit_p5_dir;
  logic hit_port5_function_select;
  logic hit_p6_pin;
  logic hit_p6_latch;
  logic hit_p6_dir;
  logic hit_port6_function_select;
  logic mapped;

  // Phase qualifiers of the current transfer.
  logic setup_phase;
  logic write_commit;
  logic lane0;

  // Write enables of the stored registers.
  logic we_p5_latch;
  logic we_p5_dir;
  logic we_port5_function_select;
  logic we_p6_latch;
  logic we_p6_dir;
  logic we_port6_function_select;

  // Read values seen by software.
  logic [7:0] rd_p5_latch;
  logic [7:0] rd_p5_dir;
  logic [7:0] rd_port5_function_select;
  logic [7:0] rd_p6_latch;
  logic [7:0] rd_p6_dir;
  logic [7:0] rd_port6_function_select;
  logic [7:0] port5_function_select_fixed;
  logic [7:0] rd_byte;

  // Combines stored bits of present pins with fixed bits of removed pins.
  function automatic logic [7:0] rpp_merge(
    input logic [7:0] stored,
    input logic [7:0] present,
    input logic [7:0] fixed
  );
    rpp_merge = (stored & present) | (fixed & ~present);
  endfunction

  // Writes only reach present bits; the rest keep their old stored value.
  function automatic logic [7:0] rpp_write(
    input logic [7:0] old_val,
    input logic [7:0] new_val,
    input logic [7:0] present
  );
    rpp_write = (new_val & present) | (old_val & ~present);
  endfunction

  always_comb begin
    word_addr = '0;
    addr_ok = 1'b1;
    if (ADDR_W > 8) begin
      if ((paddr >> 8) != '0) begin
        addr_ok = 1'b0;
      end
    end
    word_addr = paddr[7:0];
    if (word_addr[1:0] != 2'b00) begin
      addr_ok = 1'b0;
    end
  end

  always_comb begin
    hit_p5_pin = 1'b0;
    hit_p5_latch = 1'b0;
    hit_p5_dir = 1'b0;
    hit_port5_function_select = 1'b0;
    hit_p6_pin = 1'b0;
    hit_p6_latch = 1'b0;
    hit_p6_dir = 1'b0;
    hit_port6_function_select = 1'b0;
    if (!addr_ok) begin
      hit_p5_pin = 1'b0;
    end else if (word_addr == RPP_OFF_P5_PIN_STATE) begin
      hit_p5_pin = 1'b1;
    end else if (word_addr == RPP_OFF_P5_OUTPUT_LATCH) begin
      hit_p5_latch = 1'b1;
    end else if (word_addr == RPP_OFF_P5_DIRECTION) begin
      hit_p5_dir = 1'b1;
    end else if (word_addr == RPP_OFF_P5_FUNCTION_SELECT) begin
      hit_port5_function_select = 1'b1;
    end else if (word_addr == RPP_OFF_P6_PIN_STATE) begin
      hit_p6_pin = 1'b1;
    end else if (word_addr == RPP_OFF_P6_OUTPUT_LATCH) begin
      hit_p6_latch = 1'b1;
    end else if (word_addr == RPP_OFF_P6_DIRECTION) begin
      hit_p6_dir = 1'b1;
    end else if (word_addr == RPP_OFF_P6_FUNCTION_SELECT) begin
      hit_port6_function_select = 1'b1;
    end
  end

  assign mapped = hit_p5_pin | hit_p5_latch | hit_p5_dir | hit_port5_function_select |
                  hit_p6_pin | hit_p6_latch | hit_p6_dir | hit_port6_function_select;

  // The answer is prepared in the setup cycle, so every transfer takes two cycles with no wait state.
  assign setup_phase = psel & ~penable;
  assign write_commit = psel & penable & pready & pwrite & ~pslverr;
  assign lane0 = pstrb[0];

  // A write lands only at the completing edge and only through byte lane 0.
  always_comb begin
    we_p5_latch = 1'b0;
    we_p5_dir = 1'b0;
    we_port5_function_select = 1'b0;
    we_p6_latch = 1'b0;
    we_p6_dir = 1'b0;
    we_port6_function_select = 1'b0;
    if (write_commit && lane0) begin
      we_p5_latch = hit_p5_latch;
      we_p5_dir = hit_p5_dir;
      we_port5_function_select = hit_port5_function_select;
      we_p6_latch = hit_p6_latch;
      we_p6_dir = hit_p6_dir;
      we_port6_function_select = hit_port6_function_select;
    end
  end

  always_comb begin
    // Strap high clears the bit, strap low sets it. [R3]
    port5_function_select_fixed = RPP_PORT5_FUNCTION_SELECT_FIXED;
    port5_function_select_fixed[RPP_PORT5_FUNCTION_SELECT_STRAP_BIT] = ~st_q.strap;
  end

  always_comb begin
    rd_p5_latch = rpp_merge(st_q.p5_latch, RPP_P5_PRESENT, RPP_P5_ABSENT_ONES); // [R1]
    rd_p5_dir = rpp_merge(st_q.p5_dir, RPP_P5_PRESENT, RPP_P5_ABSENT_ONES); // [R1]
    // Bits 1, 4 and 6 read zero, bit 7 reads one, bit 5 follows the strap. [R2] [R4]
    rd_port5_function_select = rpp_merge(st_q.port5_function_select, RPP_P5_PRESENT, port5_function_select_fixed);
    rd_p6_latch = rpp_merge(st_q.p6_latch, RPP_P6_PRESENT, RPP_P6_ABSENT_ONES); // [R6]
    rd_p6_dir = rpp_merge(st_q.p6_dir, RPP_P6_PRESENT, RPP_P6_ABSENT_ONES); // [R6]
    rd_port6_function_select = rpp_merge(st_q.port6_function_select, RPP_P6_PRESENT, RPP_PORT6_FUNCTION_SELECT_FIXED); // [R7]
  end

  always_comb begin
    rd_byte = 8'h00;
    if (hit_p5_pin) begin
      rd_byte = port5_pin_state;
    end else if (hit_p5_latch) begin
      rd_byte = rd_p5_latch;
    end else if (hit_p5_dir) begin
      rd_byte = rd_p5_dir;
    end else if (hit_port5_function_select) begin
      rd_byte = rd_port5_function_select;
    end else if (hit_p6_pin) begin
      rd_byte = port6_pin_state;
    end else if (hit_p6_latch) begin
      rd_byte = rd_p6_latch;
    end else if (hit_p6_dir) begin
      rd_byte = rd_p6_dir;
    end else if (hit_port6_function_select) begin
      rd_byte = rd_port6_function_select;
    end
  end

  always_comb begin
    st_d = st_q;
    // The strap is sampled every cycle, so its level is taken after reset release.
    st_d.strap = external_access_strap;
    st_d.ready = setup_phase;
    st_d.slverr = 1'b0;
    if (setup_phase) begin
      st_d.slverr = ~mapped;
      if (!pwrite && mapped) begin
        st_d.rdata = {RPP_RDATA_PAD, rd_byte};
      end else begin
        st_d.rdata = RPP_RDATA_RST;
      end
    end
    // The error flag stands only in the access cycle, together with ready.
    // Writes are masked to present bits, so hardwired bits never move. [R5] [R8]
    if (we_p5_latch) begin
      st_d.p5_latch = rpp_write(st_q.p5_latch, pwdata[7:0], RPP_P5_PRESENT);
    end
    if (we_p5_dir) begin
      st_d.p5_dir = rpp_write(st_q.p5_dir, pwdata[7:0], RPP_P5_PRESENT);
    end
    if (we_port5_function_select) begin
      st_d.port5_function_select = rpp_write(st_q.port5_function_select, pwdata[7:0], RPP_P5_PRESENT);
    end
    if (we_p6_latch) begin
      st_d.p6_latch = rpp_write(st_q.p6_latch, pwdata[7:0], RPP_P6_PRESENT);
    end
    if (we_p6_dir) begin
      st_d.p6_dir = rpp_write(st_q.p6_dir, pwdata[7:0], RPP_P6_PRESENT);
    end
    if (we_port6_function_select) begin
      st_d.port6_function_select = rpp_write(st_q.port6_function_select, pwdata[7:0], RPP_P6_PRESENT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.p5_latch <= LATCH_RST & RPP_P5_PRESENT;
      st_q.p5_dir <= DIR_RST & RPP_P5_PRESENT;
      st_q.port5_function_select <= MODE_RST & RPP_P5_PRESENT;
      st_q.p6_latch <= LATCH_RST & RPP_P6_PRESENT;
      st_q.p6_dir <= DIR_RST & RPP_P6_PRESENT;
      st_q.port6_function_select <= MODE_RST & RPP_P6_PRESENT;
      st_q.strap <= RPP_STRAP_RST;
      st_q.ready <= 1'b0;
      st_q.slverr <= 1'b0;
      st_q.rdata <= RPP_RDATA_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.slverr;

  // Port 5 pin bank; removed pins are neither driven nor sampled. [R1] [R8]
  rpp_port_bank #(
    .PRESENT(RPP_P5_PRESENT),
    .ABSENT_ONES(RPP_P5_ABSENT_ONES)
  ) u_port5 (
    .pclk(pclk),
    .presetn(presetn),
    .latch(st_q.p5_latch),
    .dir(st_q.p5_dir),
    .mode(st_q.port5_function_select),
    .pin_in(port5_pin_in),
    .pin_out(port5_pin_out),
    .pin_oe(port5_pin_oe),
    .func(port5_func_sel),
    .pin_state(port5_pin_state)
  );

  // Port 6 pin bank; removed pins are neither driven nor sampled. [R6] [R8]
  rpp_port_bank #(
    .PRESENT(RPP_P6_PRESENT),
    .ABSENT_ONES(RPP_P6_ABSENT_ONES)
  ) u_port6 (
    .pclk(pclk),
    .presetn(presetn),
    .latch(st_q.p6_latch),
    .dir(st_q.p6_dir),
    .mode(st_q.port6_function_select),
    .pin_in(port6_pin_in),
    .pin_out(port6_pin_out),
    .pin_oe(port6_pin_oe),
    .func(port6_func_sel),
    .pin_state(port6_pin_state)
  );

endmodule

`default_nettype wire

// ==== bench/rpp_sva.sv ====
// Assertions on the ports of the removed-pin port read-back block.
`timescale 1ns/10ps
`default_nettype none
module rpp_sva #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Strap and pins
  input wire logic external_access_strap,
  input wire logic [7:0] port5_pin_out,
  input wire logic [7:0] port5_pin_oe,
  input wire logic [7:0] port5_func_sel,
  input wire logic [7:0] port6_pin_out,
  input wire logic [7:0] port6_pin_oe,
  input wire logic [7:0] port6_func_sel
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic setup;
  logic rd;
  assign setup = psel && !penable;
  assign rd = setup && !pwrite;
  property p_ready_after; setup |=> pready; endproperty
  a_ready_after: assert property (p_ready_after) else $error("no ready after setup");
  property p_ready_cause; pready |-> $past(setup) && prdata[31:8] == 24'h0; endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("stray ready");
  property p_unmapped; setup && (paddr >= 32 || paddr[1:0] != 0) |=> pslverr && prdata == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_p5_ones; rd && paddr inside {0, 4, 8} |=> (prdata[7:0] & 8'hF2) == 8'hF2; endproperty
  a_p5_ones: assert property (p_p5_ones) else $error("port5 removed bits not 1");
  property p_port5_function_select; rd && paddr == 12 |=> prdata[7] && !prdata[6] && !prdata[4] && !prdata[1];
  endproperty
  a_port5_function_select: assert property (p_port5_function_select) else $error("port5 mode fixed bits");
  property p_p5_strap; rd && paddr == 12 |=> prdata[5] == !$past(external_access_strap, 2);
  endproperty
  a_p5_strap: assert property (p_p5_strap) else $error("strap bit wrong");
  property p_p6_ones; rd && paddr inside {16, 20, 24} |=> prdata[3:2] == 2'b11; endproperty
  a_p6_ones: assert property (p_p6_ones) else $error("port6 removed bits not 1");
  property p_port6_function_select; rd && paddr == 28 |=> prdata[3:2] == 2'b00; endproperty
  a_port6_function_select: assert property (p_port6_function_select) else $error("port6 mode bits not 0");
  property p_pins_off;
    ((port5_pin_out | port5_pin_oe | port5_func_sel) & 8'hF2) == 0 &&
    ((port6_pin_out | port6_pin_oe | port6_func_sel) & 8'h0C) == 0;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("removed pin driven");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error flag outside access");
  c_err: cover property (setup ##1 pslverr);
  c_wr: cover property (psel && penable && pwrite && pready);
  c_mode: cover property (rd && paddr == 12);
endmodule
bind rpp_top rpp_sva #(.ADDR_W(ADDR_W)) u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .external_access_strap, .port5_pin_out, .port5_pin_oe,
  .port5_func_sel, .port6_pin_out, .port6_pin_oe, .port6_func_sel);
`default_nettype wire

// ==== bench/tb_top.sv ====
// Random and corner-case register test of the removed-pin port read-back block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, strap, err;
  logic [7:0] paddr, p5_in, p6_in, p5_out, p5_oe, p5_fn, p6_out, p6_oe, p6_fn, a;
  logic [31:0] pwdata, prdata, rd, d;
  logic [3:0] pstrb;
  logic pready, pslverr;
  logic [7:0] sh [8];
  int miscompares, comparisons, cycles, seed, i;
  rpp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_access_strap(strap),
    .port5_pin_in(p5_in), .port5_pin_out(p5_out), .port5_pin_oe(p5_oe),
    .port5_func_sel(p5_fn), .port6_pin_in(p6_in), .port6_pin_out(p6_out),
    .port6_pin_oe(p6_oe), .port6_func_sel(p6_fn));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  task give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high at a rising edge.
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd, input logic [3:0] st);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function logic [31:0] exp_rd(input logic [7:0] ad);
    logic [7:0] v;
    case (ad)
      8'h00: v = (p5_in & 8'h0D) | 8'hF2;
      8'h04, 8'h08: v = sh[ad[4:2]] | 8'hF2;
      8'h0C: v = sh[3] | 8'h80 | {2'b00, ~strap, 5'h00};
      8'h10: v = (p6_in & 8'hF3) | 8'h0C;
      8'h14, 8'h18: v = sh[ad[4:2]] | 8'h0C;
      8'h1C: v = sh[7];
      default: v = 8'h00;
    endcase
    return {24'h00_0000, v};
  endfunction
  task rdchk(input logic [7:0] ad);
    apb(0, ad, d, 4'hF);
    check(rd, exp_rd(ad));
    check({31'h0, err}, {31'h0, ad >= 8'h20 || ad[1:0] != 0});
  endtask
  initial begin
    seed = 91655;
    {psel, penable, pwrite, strap, presetn, paddr, pwdata, pstrb, p5_in, p6_in} = '0;
    sh = '{8'h00, 8'h0D, 8'h0D, 8'h00, 8'h00, 8'hF3, 8'hF3, 8'h00};
    repeat (16) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    for (i = 0; i < 9; i++) rdchk(8'(i * 4));
    for (i = 0; i < 80; i++) begin
      @(posedge pclk);
      strap <= 1'($random(seed));
      p5_in <= 8'($random(seed));
      p6_in <= 8'($random(seed));
      d = $random(seed);
      a = (i % 6 == 5) ? 8'($random(seed)) : 8'($random(seed) & 8'h1C);
      if (i < 16) a = 8'((i % 8) * 4);
      if (i < 16) d = (i < 8) ? 32'hFFFF_FFFF : 32'h0000_0000;
      apb(1, a, d, (i < 16) ? 4'hF : 4'($random(seed)));
      if (a < 8'h20 && a[1:0] == 0 && a[3:2] != 0 && pstrb[0])
        sh[a[4:2]] = d[7:0] & (a[4] ? 8'hF3 : 8'h0D);
      check({31'h0, err}, {31'h0, a >= 8'h20 || a[1:0] != 0});
      rdchk(a);
      rdchk(8'($random(seed) & 8'h1C));
      repeat (2) @(posedge pclk);
      check({p5_out, p5_oe, p5_fn}, {sh[1], ~sh[2] & 8'h0D, sh[3]});
      check({p6_out, p6_oe, p6_fn}, {sh[5], ~sh[6] & 8'hF3, sh[7]});
    end
    give_verdict();
  end
endmodule
`default_nettype wire
